// ==== core/avalon_word_slave.sv ====
`timescale 1ns/100ps
`include "pattern_params.svh"
module avalon_word_slave (
	input wire logic sys_clk, // System clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic [15:0] avs_address, // Word address.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic [31:0] avs_writedata, // Write data.
	output logic [31:0] avs_readdata, // Read data.
	output logic avs_waitrequest, // Stall while high.
	reg_access_if.slave access // Register core side.
);
	pattern_pkg::slave_state_s state;
	pattern_pkg::slave_state_s next_state;

	// Every request waits exactly one cycle, which gives read data a full register stage.
	always_comb begin
		next_state = state;
		if (sys_rst) begin
			next_state.ack = 1'b0;
			next_state.readData = `UNMAPPED_READ;
		end else if ((avs_read || avs_write) && !state.ack) begin
			next_state.ack = 1'b1;
			if (avs_read) begin
				next_state.readData = access.rdData;
			end
		end else begin
			next_state.ack = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		state <= next_state;
	end

	// A write commits only in the cycle where waitrequest is low.
	assign avs_waitrequest = (avs_read || avs_write) && !state.ack;
	assign access.wrStrobe = avs_write && state.ack;
	assign access.index = avs_address;
	assign access.wrData = avs_writedata[7:0];
	assign avs_readdata = {24'h000000, state.readData};
endmodule

// ==== core/pattern_next_data_buffer.sv ====
`timescale 1ns/100ps
`include "pattern_params.svh"
module pattern_next_data_buffer (
	input wire logic sys_clk, // System clock, 200 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic [15:0] avs_address, // Avalon word address.
	input wire logic avs_read, // Avalon read.
	input wire logic avs_write, // Avalon write.
	input wire logic [31:0] avs_writedata, // Avalon write data.
	output logic [31:0] avs_readdata, // Avalon read data.
	output logic avs_waitrequest, // Avalon wait request.
	input wire logic hwStandby, // Hardware standby pin, active high.
	input wire logic [3:0] compareMatch, // Timer channel compare-match pulses.
	output logic [7:0] patternPinLow, // Pattern outputs of groups 1 and 0.
	output logic [7:0] patternPinHigh // Pattern outputs of groups 3 and 2.
);
	pattern_pkg::core_state_s state;
	pattern_pkg::core_state_s next_state;
	reg_access_if access ();
	logic clearAll;
	logic sameLow;
	logic sameHigh;
	logic [3:0] groupTrigger;
	logic [7:0] portALatch;
	logic [7:0] portBLatch;
	logic portAWrite;
	logic portBWrite;

	////////////////////////////////////////////////////////////////////////////
	// Picks the compare-match pulse of the channel named by a select field.
	function automatic logic pickChannel(input logic [1:0] sel, input logic [3:0] cm);
		pickChannel = cm[sel];
	endfunction

	// Read view of a next-data byte at its first or alternate address.
	function automatic logic [7:0] readNext(input logic same, input logic first,
		input logic [7:0] value);
		if (same) begin
			readNext = first ? value : `RESERVED_BYTE;
		end else if (first) begin
			readNext = {value[7:4], `RESERVED_NIBBLE};
		end else begin
			readNext = {`RESERVED_NIBBLE, value[3:0]};
		end
	endfunction

	// New next-data byte after a write at its first or alternate address.
	function automatic logic [7:0] writeNext(input logic same, input logic first,
		input logic [7:0] old, input logic [7:0] data);
		if (same) begin
			writeNext = first ? data : old;
		end else if (first) begin
			writeNext = {data[7:4], old[3:0]};
		end else begin
			writeNext = {old[7:4], data[3:0]};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus front end; one wait cycle per access.
	avalon_word_slave uSlave (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.access(access.slave)
	);

	////////////////////////////////////////////////////////////////////////////
	// Standby acts only after the synchroniser, so it costs two cycles of latency.
	assign clearAll = sys_rst || state.standbySync;

	// A pair shares a trigger when both select fields name the same channel.
	assign sameLow = state.triggerSelect[`SEL_GROUP0_LSB +: `SEL_WIDTH] ==
		state.triggerSelect[`SEL_GROUP1_LSB +: `SEL_WIDTH];
	assign sameHigh = state.triggerSelect[`SEL_GROUP2_LSB +: `SEL_WIDTH] ==
		state.triggerSelect[`SEL_GROUP3_LSB +: `SEL_WIDTH];

	// Per-group trigger selection.
	assign groupTrigger[0] = pickChannel(state.triggerSelect[`SEL_GROUP0_LSB +: `SEL_WIDTH],
		compareMatch);
	assign groupTrigger[1] = pickChannel(state.triggerSelect[`SEL_GROUP1_LSB +: `SEL_WIDTH],
		compareMatch);
	assign groupTrigger[2] = pickChannel(state.triggerSelect[`SEL_GROUP2_LSB +: `SEL_WIDTH],
		compareMatch);
	assign groupTrigger[3] = pickChannel(state.triggerSelect[`SEL_GROUP3_LSB +: `SEL_WIDTH],
		compareMatch);

	// Software writes to the port latches.
	assign portAWrite = access.wrStrobe && (access.index == `ADDR_PORT_A_LATCH);
	assign portBWrite = access.wrStrobe && (access.index == `ADDR_PORT_B_LATCH);

	////////////////////////////////////////////////////////////////////////////
	// Port A latch, fed by the low next-data byte.
	pattern_port_latch uPortA (
		.sys_clk(sys_clk),
		.clear(clearAll),
		.groupTrigger(groupTrigger[1:0]),
		.nextData(state.nextLow),
		.enable(state.enableLow),
		.cpuWrite(portAWrite),
		.cpuData(access.wrData),
		.latch(portALatch)
	);

	// Port B latch, fed by the high next-data byte.
	pattern_port_latch uPortB (
		.sys_clk(sys_clk),
		.clear(clearAll),
		.groupTrigger(groupTrigger[3:2]),
		.nextData(state.nextHigh),
		.enable(state.enableHigh),
		.cpuWrite(portBWrite),
		.cpuData(access.wrData),
		.latch(portBLatch)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read decode; unmapped addresses read zero rather than stalling the bus.
	always_comb begin
		case (access.index)
			`ADDR_TRIGGER_SELECT: access.rdData = state.triggerSelect;
			`ADDR_ENABLE_HIGH: access.rdData = state.enableHigh;
			`ADDR_ENABLE_LOW: access.rdData = state.enableLow;
			`ADDR_NEXT_HIGH: access.rdData = readNext(sameHigh, 1'b1, state.nextHigh);
			`ADDR_NEXT_LOW: access.rdData = readNext(sameLow, 1'b1, state.nextLow);
			`ADDR_NEXT_HIGH_ALT: access.rdData = readNext(sameHigh, 1'b0,
				state.nextHigh);
			`ADDR_NEXT_LOW_ALT: access.rdData = readNext(sameLow, 1'b0,
				state.nextLow);
			`ADDR_PORT_A_LATCH: access.rdData = portALatch;
			`ADDR_PORT_B_LATCH: access.rdData = portBLatch;
			default: access.rdData = `UNMAPPED_READ;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Register updates; the layout in force at the write decides which nibble lands.
	always_comb begin
		next_state = state;
		next_state.standbyMeta = hwStandby;
		next_state.standbySync = state.standbyMeta;
		if (sys_rst) begin
			next_state.standbyMeta = 1'b0;
			next_state.standbySync = 1'b0;
		end
		if (clearAll) begin
			next_state.nextLow = `RESET_NEXT;
			next_state.nextHigh = `RESET_NEXT;
			next_state.enableLow = `RESET_ENABLE;
			next_state.enableHigh = `RESET_ENABLE;
			next_state.triggerSelect = `RESET_TRIGGER_SELECT;
		end else if (access.wrStrobe) begin
			case (access.index)
				`ADDR_TRIGGER_SELECT: next_state.triggerSelect = access.wrData;
				`ADDR_ENABLE_HIGH: next_state.enableHigh = access.wrData;
				`ADDR_ENABLE_LOW: next_state.enableLow = access.wrData;
				`ADDR_NEXT_HIGH: next_state.nextHigh = writeNext(sameHigh, 1'b1,
					state.nextHigh, access.wrData);
				`ADDR_NEXT_LOW: next_state.nextLow = writeNext(sameLow, 1'b1,
					state.nextLow, access.wrData);
				`ADDR_NEXT_HIGH_ALT: next_state.nextHigh = writeNext(sameHigh, 1'b0,
					state.nextHigh, access.wrData);
				`ADDR_NEXT_LOW_ALT: next_state.nextLow = writeNext(sameLow, 1'b0,
					state.nextLow, access.wrData);
				default: next_state.triggerSelect = state.triggerSelect;
			endcase
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		state <= next_state;
	end

	// Pins come straight from the latch flip-flops.
	assign patternPinLow = portALatch;
	assign patternPinHigh = portBLatch;
endmodule

// ==== core/pattern_params.svh ====
`ifndef PATTERN_PARAMS_SVH
`define PATTERN_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; the slave uses word addressing, so these are Avalon addresses.
`define ADDR_TRIGGER_SELECT 16'hFFA1
`define ADDR_ENABLE_HIGH 16'hFFA2
`define ADDR_ENABLE_LOW 16'hFFA3
`define ADDR_NEXT_HIGH 16'hFFA4
`define ADDR_NEXT_LOW 16'hFFA5
`define ADDR_NEXT_HIGH_ALT 16'hFFA6
`define ADDR_NEXT_LOW_ALT 16'hFFA7
`define ADDR_PORT_A_LATCH 16'hFFD3
`define ADDR_PORT_B_LATCH 16'hFFD6

////////////////////////////////////////////////////////////////////////////////
// Reset values and fixed read patterns.
`define RESET_NEXT 8'h00
`define RESET_ENABLE 8'h00
`define RESET_TRIGGER_SELECT 8'hFF
`define RESET_PORT_LATCH 8'h00
`define RESERVED_NIBBLE 4'hF
`define RESERVED_BYTE 8'hFF
`define UNMAPPED_READ 8'h00

////////////////////////////////////////////////////////////////////////////////
// Trigger select field positions: group g uses bits 2g+1..2g.
`define SEL_GROUP0_LSB 0
`define SEL_GROUP1_LSB 2
`define SEL_GROUP2_LSB 4
`define SEL_GROUP3_LSB 6
`define SEL_WIDTH 2

`endif

// ==== core/pattern_pkg.sv ====
package pattern_pkg;

	// State of the Avalon slave front end.
	typedef struct packed {
		logic ack;
		logic [7:0] readData;
	} slave_state_s;

	// State of one port output latch.
	typedef struct packed {
		logic [7:0] latch;
	} latch_state_s;

	// State of the register core.
	typedef struct packed {
		logic standbyMeta;
		logic standbySync;
		logic [7:0] nextLow;
		logic [7:0] nextHigh;
		logic [7:0] enableLow;
		logic [7:0] enableHigh;
		logic [7:0] triggerSelect;
	} core_state_s;

endpackage

// ==== core/pattern_port_latch.sv ====
`timescale 1ns/100ps
`include "pattern_params.svh"
module pattern_port_latch (
	input wire logic sys_clk, // System clock.
	input wire logic clear, // Synchronous clear, active high.
	input wire logic [1:0] groupTrigger, // Trigger pulse per nibble.
	input wire logic [7:0] nextData, // Next pattern byte.
	input wire logic [7:0] enable, // Per-bit pattern enable.
	input wire logic cpuWrite, // Software write pulse.
	input wire logic [7:0] cpuData, // Software write data.
	output logic [7:0] latch // Output latch.
);
	pattern_pkg::latch_state_s state;
	pattern_pkg::latch_state_s next_state;
	logic [7:0] bitTrigger;

	// Each bit follows the trigger of its own nibble group.
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : gBit
			assign bitTrigger[b] = groupTrigger[b / 4];
		end
	endgenerate

	// Enabled bits load at their trigger and are shielded from software writes.
	always_comb begin
		next_state = state;
		if (clear) begin
			next_state.latch = `RESET_PORT_LATCH;
		end else begin
			next_state.latch = (bitTrigger & enable & nextData) |
				(~(bitTrigger & enable) & state.latch);
			if (cpuWrite) begin
				next_state.latch = (~enable & cpuData) | (enable & next_state.latch);
			end
		end
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		state <= next_state;
	end

	assign latch = state.latch;
endmodule

// ==== core/reg_access_if.sv ====
`timescale 1ns/100ps
interface reg_access_if;
	logic wrStrobe;
	logic [15:0] index;
	logic [7:0] wrData;
	logic [7:0] rdData;

	modport slave (output wrStrobe, output index, output wrData, input rdData);
	modport core (input wrStrobe, input index, input wrData, output rdData);
endinterface

// ==== dv/pattern_next_data_buffer_checker.sv ====
`timescale 1ns/100ps
module pattern_checker (
	input wire logic sys_clk, // Clock.
	input wire logic sys_rst, // Reset.
	input wire logic [15:0] avs_address, // Address.
	input wire logic avs_read, // Read.
	input wire logic avs_write, // Write.
	input wire logic [31:0] avs_readdata, // Read data.
	input wire logic avs_waitrequest, // Stall.
	input wire logic hwStandby, // Standby pin.
	input wire logic [3:0] compareMatch, // Events.
	input wire logic [7:0] patternPinLow, // Port A.
	input wire logic [7:0] patternPinHigh // Port B.
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic [2:0] stbyAge;
	////////////////////////////////////////////////////////////////////////////////
	// Standby clears through a synchroniser, so its effect trails the pin.
	always_ff @(posedge sys_clk) begin
		stbyAge <= (sys_rst | hwStandby) ? 3'h5 : stbyAge - {2'h0, stbyAge != 3'h0};
	end
	sequence reqStart;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence rdDone;
		avs_read && !avs_waitrequest;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_one_wait_cycle: assert property (reqStart |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_needs_req: assert property (avs_waitrequest |-> avs_read || avs_write)
		else $error("stall without request");
	a_rd_upper_zero: assert property (rdDone |-> avs_readdata[31:8] == 24'h0)
		else $error("read upper bits set");
	a_low_alt_reserved: assert property (rdDone and avs_address == 16'hFFA7 |->
		avs_readdata[7:4] == 4'hF) else $error("low alternate upper bits not ones");
	a_high_alt_reserved: assert property (rdDone and avs_address == 16'hFFA6 |->
		avs_readdata[7:4] == 4'hF) else $error("high alternate upper bits not ones");
	a_low_pin_cause: assert property ($changed(patternPinLow) |->
		$past(|compareMatch) || $past(avs_write) || stbyAge != 3'h0)
		else $error("port A moved without cause");
	a_high_pin_cause: assert property ($changed(patternPinHigh) |->
		$past(|compareMatch) || $past(avs_write) || stbyAge != 3'h0)
		else $error("port B moved without cause");
	a_standby_clears: assert property (hwStandby [*5] |->
		patternPinLow == 8'h00 && patternPinHigh == 8'h00) else $error("standby kept pins");
	a_reset_pins_zero: assert property ($fell(sys_rst) |->
		patternPinLow == 8'h00 && patternPinHigh == 8'h00) else $error("pins not cleared");
endmodule
bind pattern_next_data_buffer pattern_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hwStandby(hwStandby),
	.compareMatch(compareMatch), .patternPinLow(patternPinLow),
	.patternPinHigh(patternPinHigh));

// ==== dv/pattern_next_data_buffer_tb.sv ====
`timescale 1ns/100ps
module pattern_next_data_buffer_tb;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] avs_address = 16'h0000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic hwStandby = 1'b0;
	logic fire = 1'b0;
	logic [1:0] chan = 2'h0;
	logic [3:0] compareMatch;
	logic [7:0] patternPinLow;
	logic [7:0] patternPinHigh;
	logic [31:0] rdq;
	int nFail = 0;
	int numChecks = 0;
	int cycles = 0;
	pattern_next_data_buffer DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .hwStandby(hwStandby), .compareMatch(compareMatch),
		.patternPinLow(patternPinLow), .patternPinHigh(patternPinHigh));
	timer_match_model timer (.sys_clk(sys_clk), .fire(fire), .chan(chan),
		.compareMatch(compareMatch));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and a ceiling far above the roughly 150 cycles the tests need.
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			nFail++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (nFail == 0 && numChecks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Comparisons of bus read data and of pin values.
	task automatic chkBus(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkPin(input logic [7:0] got, input logic [7:0] exp);
		chkBus({24'h0, got}, {24'h0, exp});
	endtask
	// One bus cycle; the request holds until waitrequest is sampled low at a rising edge.
	// Read data is taken at that same edge, and only then is the request released.
	task automatic bus(input logic rd, input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rdq = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus(1'b0, a, d);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		bus(1'b1, a, 8'h00);
		chkBus(rdq, {24'h0, e});
	endtask
	// One compare-match event, then both pin bytes one edge after it is taken.
	task automatic trig(input logic [1:0] c, input logic [7:0] lo, input logic [7:0] hi);
		@(posedge sys_clk);
		fire <= 1'b1;
		chan <= c;
		@(posedge sys_clk);
		fire <= 1'b0;
		@(posedge sys_clk);
		@(posedge sys_clk);
		#1;
		chkPin(patternPinLow, lo);
		chkPin(patternPinHigh, hi);
	endtask
	task automatic resetVals();
		rd(16'hFFA3, 8'h00);
		rd(16'hFFA2, 8'h00);
		rd(16'hFFA5, 8'h00);
		rd(16'hFFA4, 8'h00);
		rd(16'hFFA1, 8'hFF);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Shared layout first, then split triggers with group g on channel g, then standby.
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		resetVals();
		wr(16'hFFA5, 8'hA5);
		wr(16'hFFA7, 8'h00);
		rd(16'hFFA7, 8'hFF);
		rd(16'hFFA5, 8'hA5);
		wr(16'hFFA4, 8'h3C);
		wr(16'hFFA6, 8'h00);
		rd(16'hFFA6, 8'hFF);
		rd(16'hFFA4, 8'h3C);
		wr(16'hFFA3, 8'h0F);
		wr(16'hFFA2, 8'hF0);
		trig(2'h3, 8'h05, 8'h30);
		wr(16'hFFD3, 8'hFF);
		rd(16'hFFD3, 8'hF5);
		wr(16'hFFA1, 8'hE4);
		wr(16'hFFA5, 8'h9C);
		wr(16'hFFA7, 8'h6B);
		rd(16'hFFA5, 8'h9F);
		rd(16'hFFA7, 8'hFB);
		wr(16'hFFA4, 8'hD2);
		wr(16'hFFA6, 8'h47);
		rd(16'hFFA4, 8'hDF);
		rd(16'hFFA6, 8'hF7);
		wr(16'hFFA3, 8'hFF);
		wr(16'hFFA2, 8'hFF);
		trig(2'h0, 8'hFB, 8'h30);
		trig(2'h1, 8'h9B, 8'h30);
		trig(2'h2, 8'h9B, 8'h37);
		trig(2'h3, 8'h9B, 8'hD7);
		@(posedge sys_clk);
		hwStandby <= 1'b1;
		repeat (6) @(posedge sys_clk);
		hwStandby <= 1'b0;
		repeat (6) @(posedge sys_clk);
		resetVals();
		chkPin(patternPinLow, 8'h00);
		chkPin(patternPinHigh, 8'h00);
		complete_run();
	end
endmodule

// ==== dv/timer_match_model.sv ====
`timescale 1ns/100ps
module timer_match_model (
	input wire logic sys_clk, // System clock.
	input wire logic fire, // Bench asks for one event.
	input wire logic [1:0] chan, // Channel that matches.
	output logic [3:0] compareMatch // One event line per channel.
);
	// A one-cycle request gives exactly one clock-wide pulse, so no event is doubled.
	always_ff @(posedge sys_clk) begin
		compareMatch <= fire ? (4'h1 << chan) : 4'h0;
	end
endmodule
